// *** hdl/twsf_map.svh ***
// register offsets, field positions and timing constants of the two-wire flag block
// assumes a 50 MHz clock and 32-bit AXI4-Lite access, one register per aligned word
`ifndef TWSF_MAP_SVH
`define TWSF_MAP_SVH
// byte offsets
`define TWSF_A_CTRL    8'h00
`define TWSF_A_STATUS  8'h04
`define TWSF_A_CMD     8'h08
`define TWSF_A_DATA    8'h0C
`define TWSF_A_ISTAT   8'h10
`define TWSF_A_ICLR    8'h14
`define TWSF_A_IEN     8'h18
`define TWSF_A_OWN     8'h1C
// control fields
`define TWSF_B_EN      0
`define TWSF_B_TMO_EN  1
// status fields
`define TWSF_B_ADDR_STOP 0
`define TWSF_B_DATA_FLAG 1
`define TWSF_B_HOLD    2
`define TWSF_B_TXCOL   3
// interrupt event bits
`define TWSF_IRQ_W     4
`define TWSF_E_ADDR    0
`define TWSF_E_STOP    1
`define TWSF_E_DATA    2
`define TWSF_E_TMO     3
// slave response command code
`define TWSF_CMD_RESP  2'h3
// reset values
`define TWSF_RST_OWN   7'h00
`define TWSF_RST_DATA  32'h0000_0000
// bus timeout
`define TWSF_TMO_US    100
`define TWSF_CLK_MHZ   50
`define TWSF_TMO_CYC   (`TWSF_TMO_US * `TWSF_CLK_MHZ)
// bus answers
`define TWSF_OKAY      2'h0
`define TWSF_SLVERR    2'h2
`endif

// *** hdl/twsf_pkg.sv ***
// types shared by the two-wire flag block
// assumes nothing beyond a SystemVerilog compiler
package twsf_pkg;
    // bus line state as software sees it
    typedef enum logic [1:0] {
        LN_IDLE,
        LN_BUSY
    } twsf_line_e;

    // slave receive sequencer
    typedef enum logic [1:0] {
        SL_IDLE,
        SL_ADDR,
        SL_DATA
    } twsf_slv_e;

    // status word carried to the read mux
    typedef struct packed {
        twsf_line_e line_state_field;
        logic       tx_col;
        logic       clock_stretch_hold;
        logic       data_irq_flag;
        logic       addr_stop_irq_flag;
    } twsf_stat_s;
endpackage : twsf_pkg

// *** hdl/twsf_sync.sv ***
// two-flop synchroniser for one pin input
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module twsf_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin and synchronised level
    input  wire logic pin_in,
    output logic      pin_s
);
    logic meta_r;

    // first stage feeds only the second; idle bus level is high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b1;
            pin_s  <= 1'b1;
        end else begin
            meta_r <= pin_in;
            pin_s  <= meta_r;
        end
    end
endmodule : twsf_sync

// *** hdl/twsf_top.sv ***
// two-wire slave flag and clock-hold logic with an AXI4-Lite register slave
// assumes open-drain scl/sda resolved outside; one 50 MHz clock, async active-low reset
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "twsf_map.svh"
module twsf_top
    import twsf_pkg::*;
#(
    parameter int unsigned TMO_CYC = `TWSF_TMO_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // two-wire pins
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // interrupt
    output logic             irq
);
    logic        scl_s, sda_s, scl_d_r, sda_d_r;
    logic        aw_got_r, w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_fire, wr_lo, ar_fire;
    logic        en_r, tmo_en_r;
    logic [6:0]  own_r;
    logic [7:0]  rx_r, sh_r, sh_nxt;
    logic        as_flag_r, dflag_r, hold_r, txcol_r, dflag_pend_r, ack_r;
    twsf_line_e  line_r;
    twsf_slv_e   slv_r;
    logic [3:0]  bit_r;
    logic [31:0] tmo_r;
    logic [`TWSF_IRQ_W-1:0] ist_r, ien_r, iev;
    logic        scl_rise, scl_fall, start, stop, tmo_hit, start_ok;
    logic        byte_done, addr_hit, data_hit;
    logic        as_flag_set, as_flag_clr, cmd_go, txcol_set;
    twsf_stat_s  stat;

    // pins cross into clk before anything looks at them
    twsf_sync u_scl (.clk(clk), .rst_n(rst_n), .pin_in(scl_in), .pin_s(scl_s));
    twsf_sync u_sda (.clk(clk), .rst_n(rst_n), .pin_in(sda_in), .pin_s(sda_s));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // bus conditions
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start    = en_r & scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop     = en_r & scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign tmo_hit  = tmo_en_r & (line_r == LN_BUSY) & (tmo_r == TMO_CYC - 1);
    assign start_ok = start & ~tmo_hit;
    assign sh_nxt   = {sh_r[6:0], sda_s};
    assign byte_done = scl_rise & (bit_r == 4'h7) & (slv_r != SL_IDLE);
    assign addr_hit  = byte_done & (slv_r == SL_ADDR) & (sh_nxt[7:1] == own_r);
    assign data_hit  = byte_done & (slv_r == SL_DATA);

    // axi write side: address and data taken in either order, answered together
    assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
    assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
    assign wr_lo   = wr_fire & wstrb_r[0];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            awaddr_r     <= 8'h00;
            wdata_r      <= `TWSF_RST_DATA;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TWSF_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r > `TWSF_A_OWN || awaddr_r[1:0] != 2'h0) ? `TWSF_SLVERR : `TWSF_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software-steered configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r     <= 1'b0;
            tmo_en_r <= 1'b0;
            own_r    <= `TWSF_RST_OWN;
            ien_r    <= '0;
        end else if (wr_lo) begin
            case (awaddr_r)
                `TWSF_A_CTRL: begin
                    en_r     <= wdata_r[`TWSF_B_EN];
                    tmo_en_r <= wdata_r[`TWSF_B_TMO_EN];
                end
                `TWSF_A_OWN: own_r <= wdata_r[6:0];
                `TWSF_A_IEN: ien_r <= wdata_r[`TWSF_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // software strobes
    assign as_flag_clr = wr_lo & (awaddr_r == `TWSF_A_STATUS) & wdata_r[`TWSF_B_ADDR_STOP];
    assign cmd_go    = wr_lo & (awaddr_r == `TWSF_A_CMD) & (wdata_r[1:0] == `TWSF_CMD_RESP);
    // a data write with scl not held cannot be placed on the bus
    assign txcol_set = wr_lo & (awaddr_r == `TWSF_A_DATA) & ~hold_r;
    assign as_flag_set = addr_hit | stop;

    // line state and bus timeout counter, restarted by every scl edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_r <= LN_IDLE;
            tmo_r  <= 32'h0000_0000;
        end else begin
            if (tmo_hit | stop | ~en_r) line_r <= LN_IDLE;
            else if (start) line_r <= LN_BUSY;
            if (line_r != LN_BUSY || scl_rise || scl_fall) tmo_r <= 32'h0000_0000;
            else tmo_r <= tmo_r + 32'h0000_0001;
        end
    end

    // receive sequencer: address byte, then data bytes, ninth clock is the ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slv_r <= SL_IDLE;
            bit_r <= 4'h0;
            sh_r  <= 8'h00;
            rx_r  <= 8'h00;
        end else begin
            if (tmo_hit | stop | ~en_r) begin
                slv_r <= SL_IDLE;
            end else if (start_ok) begin
                slv_r <= SL_ADDR;
                bit_r <= 4'h0;
            end else if (scl_rise) begin
                case (slv_r)
                    SL_ADDR, SL_DATA: begin
                        if (bit_r == 4'h8) begin
                            bit_r <= 4'h0;
                        end else begin
                            sh_r  <= sh_nxt;
                            bit_r <= bit_r + 4'h1;
                        end
                        if (byte_done && slv_r == SL_ADDR) slv_r <= addr_hit ? SL_DATA : SL_IDLE;
                        if (data_hit) rx_r <= sh_nxt;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ack drive: pull sda low across the ninth clock of an accepted byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r  <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            if (addr_hit | data_hit) ack_r <= 1'b1;
            else if (scl_fall && bit_r == 4'h8 && ack_r) begin
                ack_r  <= 1'b0;
                sda_oe <= 1'b1;
            end
            if ((scl_fall && bit_r == 4'h0) || stop || tmo_hit) sda_oe <= 1'b0;
        end
    end

    // address/stop flag and clock hold; a set in the clear cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            as_flag_r <= 1'b0;
            hold_r    <= 1'b0;
        end else begin
            if (as_flag_set) as_flag_r <= 1'b1;
            else if (as_flag_clr) as_flag_r <= 1'b0;
            if (addr_hit | data_hit) hold_r <= 1'b1;
            else if ((as_flag_clr & ~as_flag_set) | cmd_go | tmo_hit | stop) hold_r <= 1'b0;
        end
    end

    // data flag cleared a cycle after the response command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dflag_r      <= 1'b0;
            dflag_pend_r <= 1'b0;
        end else begin
            dflag_pend_r <= cmd_go;
            if (data_hit) dflag_r <= 1'b1;
            else if (dflag_pend_r) dflag_r <= 1'b0;
        end
    end

    // transmit collision: plain start clears it, repeated start does not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) txcol_r <= 1'b0;
        else if (txcol_set) txcol_r <= 1'b1;
        else if (start_ok && line_r == LN_IDLE) txcol_r <= 1'b0;
        else if (wr_lo && awaddr_r == `TWSF_A_STATUS && wdata_r[`TWSF_B_TXCOL]) txcol_r <= 1'b0;
    end

    // scl pulled low only once low, so a high phase is never cut short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) scl_oe <= 1'b0;
        else scl_oe <= hold_r & (scl_oe | ~scl_s);
    end
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // sticky interrupt status, set wins over the clear register
    assign iev = {tmo_hit, data_hit, stop, addr_hit};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ist_r <= '0;
        else if (wr_lo && awaddr_r == `TWSF_A_ICLR) ist_r <= (ist_r & ~wdata_r[`TWSF_IRQ_W-1:0]) | iev;
        else ist_r <= ist_r | iev;
    end
    assign irq = |(ist_r & ien_r);

    // read side, one outstanding read
    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_fire = s_axi_arvalid & s_axi_arready;
    assign stat = '{line_state_field: line_r, tx_col: txcol_r, clock_stretch_hold: hold_r,
                    data_irq_flag: dflag_r, addr_stop_irq_flag: as_flag_r};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `TWSF_RST_DATA;
            s_axi_rresp  <= `TWSF_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `TWSF_OKAY;
            case (s_axi_araddr)
                `TWSF_A_CTRL:   s_axi_rdata <= {30'h0, tmo_en_r, en_r};
                `TWSF_A_STATUS: s_axi_rdata <= {26'h0, stat};
                `TWSF_A_DATA:   s_axi_rdata <= {24'h0, rx_r};
                `TWSF_A_ISTAT:  s_axi_rdata <= {28'h0, ist_r};
                `TWSF_A_IEN:    s_axi_rdata <= {28'h0, ien_r};
                `TWSF_A_OWN:    s_axi_rdata <= {25'h0, own_r};
                `TWSF_A_CMD, `TWSF_A_ICLR: s_axi_rdata <= `TWSF_RST_DATA;
                default: begin
                    s_axi_rdata <= `TWSF_RST_DATA;
                    s_axi_rresp <= `TWSF_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    start_clr_txcol_a: assert property (@(posedge clk) disable iff (!rst_n)
        start_ok && line_r == LN_IDLE && !txcol_set |=> !txcol_r) else $error("start left txcol set");
    rstart_keep_txcol_a: assert property (@(posedge clk) disable iff (!rst_n)
        start && line_r == LN_BUSY && txcol_r && !wr_lo |=> txcol_r) else $error("repeated start cleared txcol");
    race_keep_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        as_flag_clr && addr_hit |=> as_flag_r && hold_r) else $error("clear race released hold");
    tmo_start_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        start && tmo_hit |=> slv_r == SL_IDLE && line_r == LN_IDLE) else $error("start kept at timeout");
    dflag_late_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_go && dflag_r && !data_hit ##1 !data_hit |=> !dflag_r) else $error("data flag not cleared on time");
    dflag_read_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_go && dflag_r |=> dflag_r) else $error("data flag cleared too early");
    hold_drive_scl_a: assert property (@(posedge clk) disable iff (!rst_n)
        hold_r && !scl_s && $stable(hold_r) |=> scl_oe) else $error("hold without scl low");
    // an event in the cycle of a status clear must still land
    ist_set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        iev != '0 |=> (ist_r & $past(iev)) == $past(iev)) else $error("event lost to clear");
    bvalid_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    addr_match_c: cover property (@(posedge clk) disable iff (!rst_n) addr_hit);
    race_c: cover property (@(posedge clk) disable iff (!rst_n) as_flag_clr && addr_hit);
    resp_cmd_c: cover property (@(posedge clk) disable iff (!rst_n) cmd_go && dflag_r);
    tmo_start_c: cover property (@(posedge clk) disable iff (!rst_n) start && tmo_hit);
endmodule : twsf_top

// *** verification/tb.sv ***
// self-checking bench: axi4-lite register master plus a bus master model
// assumes pull-ups on both lines and a small timeout count
`timescale 1ns/1ps
`include "twsf_map.svh"
module tb
    import twsf_pkg::*;
;
    localparam int unsigned TMO = 20;
    logic        clk, rst_n, awv, wv, bre, arv, rre, w_acc, ack;
    logic        awr, wr, bv, arr, rv, scl_oe, sda_oe, scl_o, sda_o, irq;
    logic        m_scl, m_sda, scl_w, sda_w;
    logic [7:0]  awa, ara, byt;
    logic [31:0] wd, rd, rdat;
    logic [3:0]  ws;
    logic [1:0]  br, rr, resp;
    logic [6:0]  own;
    int          errors, cmp_count, seed;

    twsf_top #(.TMO_CYC(TMO)) u_dut (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe), .irq(irq));
    twsf_bus_model u_bus (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));

    // wired-and lines with pull-ups
    assign scl_w = ~(m_scl | (scl_oe & ~scl_o));
    assign sda_w = ~(m_sda | (sda_oe & ~sda_o));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic results();
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            $display("[FAIL] %0t %s", $time, m);
            errors++;
        end
    endtask : chk

    task automatic tmo(input bit hit);
        if (hit) begin
            $display("[FAIL] %0t wait timed out", $time);
            errors++;
            results();
        end
    endtask : tmo

    // w_acc marks the edge where both aw and w were taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic ta, tw, pa, pw;
        @(posedge clk);
        awa <= a;
        wd  <= d;
        ws  <= 4'hF;
        awv <= 1'b1;
        wv  <= 1'b1;
        bre <= 1'b1;
        // pending flags: the valids still read their old value in this time step
        pa = 1'b1;
        pw = 1'b1;
        n = 0;
        while ((pa | pw) && n < 200) begin
            @(negedge clk);
            ta = pa & awr;
            tw = pw & wr;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            pa = pa & ~ta;
            pw = pw & ~tw;
            w_acc = ~(pa | pw);
            n++;
        end
        do begin
            @(negedge clk);
            n++;
        end while (!bv && n < 400);
        resp = br;
        @(posedge clk);
        bre <= 1'b0;
        w_acc = 1'b0;
        tmo(n >= 400);
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!arr && n < 200);
        @(posedge clk);
        arv <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (!rv && n < 400);
        d = rdat;
        r = rr;
        @(posedge clk);
        rre <= 1'b0;
        tmo(n >= 400);
    endtask : axr

    // masked read compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
        logic [31:0] d;
        logic [1:0]  r;
        axr(a, d, r);
        chk(d & m, e, s);
    endtask : rdc

    task automatic wait_hold();
        int n;
        n = 0;
        while (scl_oe !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        tmo(n >= 2000);
    endtask : wait_hold

    initial begin
        seed = 32'h46516a14;
        errors = 0;
        cmp_count = 0;
        {rst_n, awv, wv, bre, arv, rre, w_acc} = '0;
        {awa, ara, wd, ws} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and unmapped place
        rdc(`TWSF_A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl reset");
        rdc(`TWSF_A_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, "status reset");
        rdc(`TWSF_A_DATA, 32'hFFFF_FFFF, `TWSF_RST_DATA, "data reset");
        rdc(`TWSF_A_OWN, 32'hFFFF_FFFF, {25'h0, `TWSF_RST_OWN}, "own reset");
        axr(8'h20, rd, resp);
        chk(resp, `TWSF_SLVERR, "unmapped read");
        axw(8'h20, 32'h0000_0001);
        chk(resp, `TWSF_SLVERR, "unmapped write");
        own = 7'($random(seed));
        axw(`TWSF_A_OWN, {25'h0, own});
        axw(`TWSF_A_IEN, 32'h0000_000F);
        axw(`TWSF_A_CTRL, 32'h0000_0001);
        // collision raised while idle, start from idle clears it
        axw(`TWSF_A_DATA, 32'h0000_00A5);
        rdc(`TWSF_A_STATUS, 32'h0000_0008, 32'h0000_0008, "txcol set");
        u_bus.start();
        rdc(`TWSF_A_STATUS, 32'h0000_0038, 32'h0000_0010, "start keeps txcol");
        // foreign address: no ack
        u_bus.put_byte({own ^ 7'h01, 1'b0}, ack);
        chk(ack, 1'b0, "foreign ack");
        axw(`TWSF_A_DATA, 32'h0000_005A);
        u_bus.start();
        rdc(`TWSF_A_STATUS, 32'h0000_0008, 32'h0000_0008, "rep start cleared txcol");
        axw(`TWSF_A_STATUS, 32'h0000_0008);
        rdc(`TWSF_A_STATUS, 32'h0000_0008, 32'h0000_0000, "txcol not cleared");
        // own address: scl stretched until the response command
        fork
            u_bus.put_byte({own, 1'b0}, ack);
            begin
                wait_hold();
                rdc(`TWSF_A_STATUS, 32'h0000_0007, 32'h0000_0005, "addr hold");
                chk(scl_w, 1'b0, "scl not held");
                chk(irq, 1'b1, "irq on addr");
                axw(`TWSF_A_CMD, {30'h0, `TWSF_CMD_RESP});
            end
        join
        chk({ack, u_bus.stuck}, 2'b10, "addr ack or lock");
        // data byte, flag clear one cycle after the response command
        byt = 8'($random(seed));
        fork
            u_bus.put_byte(byt, ack);
            begin
                wait_hold();
                // a command code other than the response must not release the hold
                axw(`TWSF_A_CMD, 32'h0000_0001);
                rdc(`TWSF_A_STATUS, 32'h0000_0006, 32'h0000_0006, "data hold");
                fork
                    axw(`TWSF_A_CMD, {30'h0, `TWSF_CMD_RESP});
                    begin
                        int k;
                        k = 0;
                        while (!w_acc && k < 400) begin
                            @(negedge clk);
                            k++;
                        end
                        tmo(k >= 400);
                        axr(`TWSF_A_STATUS, rd, resp);
                    end
                join
                chk(rd[`TWSF_B_DATA_FLAG], 1'b1, "data flag cleared early");
                rdc(`TWSF_A_STATUS, 32'h0000_0002, 32'h0000_0000, "data flag stays");
            end
        join
        chk({ack, u_bus.stuck}, 2'b10, "data ack or lock");
        rdc(`TWSF_A_DATA, 32'h0000_00FF, {24'h0, byt}, "rx byte");
        // stop, then clear the address/stop flag with idle bus and no hold
        u_bus.stop();
        rdc(`TWSF_A_STATUS, 32'h0000_0035, 32'h0000_0001, "stop status");
        rdc(`TWSF_A_ISTAT, 32'h0000_000F, 32'h0000_0007, "events");
        axw(`TWSF_A_STATUS, 32'h0000_0001);
        rdc(`TWSF_A_STATUS, 32'h0000_0001, 32'h0000_0000, "addr flag kept");
        // interrupt masked then cleared
        axw(`TWSF_A_IEN, 32'h0000_0000);
        chk(irq, 1'b0, "irq masked");
        axw(`TWSF_A_ICLR, 32'h0000_000F);
        axw(`TWSF_A_IEN, 32'h0000_000F);
        chk(irq, 1'b0, "irq not cleared");
        // stalled bus times out
        axw(`TWSF_A_CTRL, 32'h0000_0003);
        u_bus.start();
        repeat (3 * TMO) @(posedge clk);
        rdc(`TWSF_A_STATUS, 32'h0000_0030, 32'h0000_0000, "timeout idle");
        rdc(`TWSF_A_ISTAT, 32'h0000_0008, 32'h0000_0008, "timeout event");
        chk(irq, 1'b1, "irq on timeout");
        results();
    end
endmodule : tb

// *** verification/twsf_bus_model.sv ***
// two-wire bus master model: start, stop and byte writes with ack sampling
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ps
module twsf_bus_model (
    // clock
    input  wire logic clk,
    // resolved lines
    input  wire logic scl,
    input  wire logic sda,
    // pull-low enables
    output logic      scl_pull,
    output logic      sda_pull
);
    int unsigned q = 6;
    logic        stuck;

    // lines released at power-up
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        stuck    = 1'b0;
    end

    // a third of a put_byte bit period: scl low for two of these, high for one
    task automatic wq();
        repeat (q) @(posedge clk);
    endtask : wq

    // release scl, wait while a slave stretches it; bounded so a lock shows as stuck
    task automatic scl_hi();
        int n;
        n = 0;
        scl_pull <= 1'b0;
        @(posedge clk);
        while (scl !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        stuck = (scl !== 1'b1);
    endtask : scl_hi

    // start from idle, or repeated start with scl low
    task automatic start();
        sda_pull <= 1'b0;
        wq();
        scl_hi();
        wq();
        sda_pull <= 1'b1;
        wq();
        scl_pull <= 1'b1;
        wq();
    endtask : start

    // stop, entered with scl low
    task automatic stop();
        sda_pull <= 1'b1;
        wq();
        scl_hi();
        wq();
        sda_pull <= 1'b0;
        wq();
    endtask : stop

    // msb first; sda only moves a third of a bit period after scl falls
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull <= ~b[i];
            wq();
            scl_hi();
            wq();
            scl_pull <= 1'b1;
            wq();
        end
        sda_pull <= 1'b0;
        wq();
        scl_hi();
        ack = ~sda;
        wq();
        scl_pull <= 1'b1;
        wq();
    endtask : put_byte
endmodule : twsf_bus_model
